// file: core/ptr_interp_pkg.sv
package ptr_interp_pkg;

	// Register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_POINTER = 4'h8;

	// Control field positions
	localparam int CTRL_SS_DIS_BIT = 0;
	localparam int CTRL_SPACE_DIS_BIT = 1;
	localparam int CTRL_ILLEGAL_DIS_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// Status field positions
	localparam int STS_INV_PTR_BIT = 0;
	localparam int STS_BAD_NDF_BIT = 1;
	localparam int STS_NEW_PTR_BIT = 2;
	localparam int STS_DISCONT_BIT = 3;
	localparam int STS_ILLEGAL_BIT = 4;
	localparam int STS_STATE_LSB = 8;
	localparam logic [4:0] STS_RST = 5'h00;

	// Pointer word layout and limits
	localparam logic [9:0] PTR_MAX = 10'h30e;
	localparam logic [9:0] PTR_RST = 10'h000;
	localparam logic [1:0] SS_SDH = 2'h2;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [2:0] MAJORITY = 3'h3;

	// Frame counts for consecutive runs and adjustment spacing
	localparam logic [1:0] SPACING_FRAMES = 2'h3;
	localparam logic [1:0] AIS_RUN = 2'h3;
	localparam logic [1:0] EQ_RUN = 2'h3;
	localparam logic [3:0] INV_RUN = 4'h8;
	localparam logic [3:0] NDF_RUN = 4'h8;

	typedef enum logic [2:0] {
		ST_NORM = 3'b001,
		ST_AIS = 3'b010,
		ST_LOP = 3'b100
	} pi_state_t;

	typedef struct packed {
		logic norm;
		logic ndf;
		logic ais;
		logic inc;
		logic dec;
		logic inv;
		logic bad_ndf;
		logic newp;
		logic illegal;
	} ptr_event_t;

endpackage

// file: core/sonet_pointer_interpreter.sv
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// Register map, byte offsets:
// 0x0 control: bit0 drops size check, bit1 drops spacing, bit2 drops illegal flag
// 0x4 status: bits 4:0 sticky, write one to clear; bits 10:8 one-hot state
// 0x8 pointer: bits 9:0 active offset, read only

// Majority vote over a small group of bits
module bit_vote5 #(
	parameter int WIDTH = 5, // Bits voted on
	parameter int NEED = 3 // Set bits that make a majority
) (
	input wire logic [WIDTH-1:0] bits_in, // Bits to count
	output logic hit // At least NEED bits set
);
	logic [7:0] ones;

	always_comb begin
		ones = 8'h00;
		for (int k = 0; k < WIDTH; k++) begin
			ones = ones + {7'h00, bits_in[k]};
		end
		hit = ones >= 8'(NEED);
	end
endmodule

module sonet_pointer_interpreter
	import ptr_interp_pkg::*;
(
	input wire logic mclk, // 25 MHz byte-rate clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [7:0] h1_byte, // First pointer byte
	input wire logic [7:0] h2_byte, // Second pointer byte
	input wire logic ptr_valid, // One pulse per frame, bytes valid
	input wire logic [3:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall until access done
	output logic path_alarm_out, // Path alarm state indication
	output logic pointer_lost_out // Pointer lost state indication
);

	pi_state_t state_ff, nxt_state;
	logic [9:0] active_ff, nxt_active;
	logic [9:0] cand_ff;
	logic [1:0] ais_cnt_ff, eq_cnt_ff, since_ff;
	logic [3:0] inv_cnt_ff, ndf_cnt_ff;
	logic [2:0] ctrl_ff;
	logic [4:0] sts_ff;
	logic path_alarm_ff, pointer_lost_ff;
	logic wait_ff;
	logic [31:0] rdata_ff;

	ptr_event_t ev;
	logic [3:0] ndf_code;
	logic [1:0] ss_bits;
	logic [9:0] rx_ptr, diff;
	logic ndf_on, ndf_off, ss_ok, in_range, valid_off;
	logic i_maj, d_maj, spacing_ok, inc_raw, dec_raw;
	logic trk, eq_hit, changed, discont;
	logic acc, wr_ok;
	logic [4:0] sts_set, sts_clr;

	assign ndf_code = h1_byte[7:4];
	assign ss_bits = h1_byte[3:2];
	assign rx_ptr = {h1_byte[1:0], h2_byte};
	assign diff = rx_ptr ^ active_ff;

	// Flag code classes
	always_comb begin
		ndf_on = 1'b0;
		ndf_off = 1'b0;
		case (ndf_code)
			4'h9, 4'h1, 4'hd, 4'hb, 4'h8: ndf_on = 1'b1;
			4'h6, 4'he, 4'h2, 4'h4, 4'h7: ndf_off = 1'b1;
			default: ;
		endcase
	end

	assign ss_ok = ctrl_ff[CTRL_SS_DIS_BIT] | (ss_bits == SS_SDH);
	assign in_range = rx_ptr <= PTR_MAX;
	assign valid_off = ndf_off & ss_ok & in_range;
	// I bits sit at odd positions from the top, D bits interleave them
	bit_vote5 #(
		.WIDTH(5),
		.NEED(int'(MAJORITY))
	) i_vote_u (
		.bits_in({diff[9], diff[7], diff[5], diff[3], diff[1]}),
		.hit(i_maj)
	);
	bit_vote5 #(
		.WIDTH(5),
		.NEED(int'(MAJORITY))
	) d_vote_u (
		.bits_in({diff[8], diff[6], diff[4], diff[2], diff[0]}),
		.hit(d_maj)
	);
	assign spacing_ok = ctrl_ff[CTRL_SPACE_DIS_BIT] | (since_ff >= SPACING_FRAMES);
	assign inc_raw = ndf_off & ss_ok & i_maj & ~d_maj;
	assign dec_raw = ndf_off & ss_ok & d_maj & ~i_maj;

	// Per-frame event decode, all quiet between frames
	always_comb begin
		ev = '0;
		if (ptr_valid) begin
			ev.norm = ndf_off & ss_ok & (rx_ptr == active_ff);
			ev.ndf = ndf_on & ss_ok & in_range;
			ev.ais = (h1_byte == ALL_ONES) & (h2_byte == ALL_ONES);
			ev.inc = inc_raw & spacing_ok;
			ev.dec = dec_raw & spacing_ok;
			ev.inv = ~(ev.norm | ev.ndf | ev.ais | ev.inc | ev.dec);
			ev.bad_ndf = ~ndf_on & ~ndf_off & ~ev.ais;
			ev.newp = valid_off & (rx_ptr != active_ff) & ~ev.inc & ~ev.dec;
			ev.illegal = (inc_raw | dec_raw) & (since_ff < SPACING_FRAMES)
				& ~ctrl_ff[CTRL_ILLEGAL_DIS_BIT];
		end
	end

	// Active offset is undefined outside normal, so any steady valid pointer counts there
	assign trk = ptr_valid & ((state_ff == ST_NORM) ? ev.newp : valid_off);
	assign eq_hit = trk & (eq_cnt_ff == EQ_RUN - 2'h1) & (rx_ptr == cand_ff);

	always_comb begin
		nxt_state = state_ff;
		nxt_active = active_ff;
		discont = 1'b0;
		case (state_ff)
			ST_NORM: begin
				if (eq_hit) begin
					nxt_active = rx_ptr;
					discont = 1'b1;
				end else if (ev.inc) begin
					nxt_active = (active_ff == PTR_MAX) ? PTR_RST : active_ff + 10'h001;
				end else if (ev.dec) begin
					nxt_active = (active_ff == PTR_RST) ? PTR_MAX : active_ff - 10'h001;
				end else if (ev.ndf) begin
					nxt_active = rx_ptr;
				end
				if (ev.ais && ais_cnt_ff == AIS_RUN - 2'h1) begin
					nxt_state = ST_AIS;
				end else if (!eq_hit && ev.inv && inv_cnt_ff == INV_RUN - 4'h1) begin
					nxt_state = ST_LOP;
				end else if (ev.ndf && ndf_cnt_ff == NDF_RUN - 4'h1) begin
					nxt_state = ST_LOP;
				end
			end
			ST_AIS: begin
				if (ev.ndf || eq_hit) begin
					nxt_state = ST_NORM;
					nxt_active = rx_ptr;
				end else if (ev.inv && inv_cnt_ff == INV_RUN - 4'h1) begin
					nxt_state = ST_LOP;
				end
			end
			ST_LOP: begin
				if (eq_hit) begin
					nxt_state = ST_NORM;
					nxt_active = rx_ptr;
				end else if (ev.ais && ais_cnt_ff == AIS_RUN - 2'h1) begin
					nxt_state = ST_AIS;
				end
			end
			default: begin
				nxt_state = ST_LOP;
			end
		endcase
	end

	assign changed = nxt_state != state_ff;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_LOP;
			active_ff <= PTR_RST;
		end else begin
			state_ff <= nxt_state;
			active_ff <= nxt_active;
		end
	end

	// Consecutive-event counters
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ais_cnt_ff <= 2'h0;
			inv_cnt_ff <= 4'h0;
			ndf_cnt_ff <= 4'h0;
			eq_cnt_ff <= 2'h0;
			cand_ff <= PTR_RST;
		end else if (changed) begin
			ais_cnt_ff <= 2'h0;
			inv_cnt_ff <= 4'h0;
			ndf_cnt_ff <= 4'h0;
			eq_cnt_ff <= 2'h0;
		end else if (ptr_valid) begin
			ais_cnt_ff <= !ev.ais ? 2'h0 : (ais_cnt_ff == AIS_RUN ? AIS_RUN : ais_cnt_ff + 2'h1);
			inv_cnt_ff <= !ev.inv ? 4'h0 : (inv_cnt_ff == INV_RUN ? INV_RUN : inv_cnt_ff + 4'h1);
			ndf_cnt_ff <= !ev.ndf ? 4'h0 : (ndf_cnt_ff == NDF_RUN ? NDF_RUN : ndf_cnt_ff + 4'h1);
			cand_ff <= rx_ptr;
			if (!trk || eq_hit) begin
				eq_cnt_ff <= 2'h0;
			end else if (eq_cnt_ff != 2'h0 && rx_ptr == cand_ff) begin
				eq_cnt_ff <= eq_cnt_ff + 2'h1;
			end else begin
				eq_cnt_ff <= 2'h1;
			end
		end
	end

	// Frames since the last accepted adjustment or flag-enabled event
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			since_ff <= SPACING_FRAMES;
		end else if (ptr_valid) begin
			if (ev.inc || ev.dec || ev.ndf) begin
				since_ff <= 2'h0;
			end else if (since_ff != SPACING_FRAMES) begin
				since_ff <= since_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			path_alarm_ff <= 1'b0;
			pointer_lost_ff <= 1'b0;
		end else begin
			path_alarm_ff <= nxt_state == ST_AIS;
			pointer_lost_ff <= nxt_state == ST_LOP;
		end
	end

	// Avalon slave: one wait cycle, then the access completes
	assign acc = (avs_read | avs_write) & ~wait_ff;
	assign wr_ok = acc & avs_write & avs_byteenable[0];

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wait_ff <= 1'b1;
		end else if (wait_ff) begin
			wait_ff <= ~(avs_read | avs_write);
		end else begin
			wait_ff <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (wait_ff && avs_read) begin
			case (avs_address)
				OFS_CTRL: rdata_ff <= {29'h0000_0000, ctrl_ff};
				OFS_STATUS: rdata_ff <= {21'h00_0000, state_ff, 3'h0, sts_ff};
				OFS_POINTER: rdata_ff <= {22'h00_0000, active_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_ok && avs_address == OFS_CTRL) begin
			ctrl_ff <= avs_writedata[2:0];
		end
	end

	always_comb begin
		sts_set = '0;
		sts_set[STS_INV_PTR_BIT] = ev.inv;
		sts_set[STS_BAD_NDF_BIT] = ev.bad_ndf;
		sts_set[STS_NEW_PTR_BIT] = ev.newp & ~eq_hit;
		sts_set[STS_DISCONT_BIT] = discont;
		sts_set[STS_ILLEGAL_BIT] = ev.illegal;
		sts_clr = (wr_ok && avs_address == OFS_STATUS) ? avs_writedata[4:0] : 5'h00;
	end

	// Write-one-to-clear; a new event in the same cycle survives
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sts_ff <= STS_RST;
		end else begin
			sts_ff <= (sts_ff & ~sts_clr) | sts_set;
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = wait_ff;
	assign path_alarm_out = path_alarm_ff;
	assign pointer_lost_out = pointer_lost_ff;

endmodule

`default_nettype wire

// file: dv/sonet_pointer_interpreter_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sonet_pointer_interpreter_checker import ptr_interp_pkg::*; (
	input wire logic mclk, // Byte clock
	input wire logic arst_n, // Async reset
	input wire logic [7:0] h1_byte, // Pointer byte one
	input wire logic [7:0] h2_byte, // Pointer byte two
	input wire logic ptr_valid, // Frame strobe
	input wire logic avs_read, // Bus read
	input wire logic avs_write, // Bus write
	input wire logic avs_waitrequest, // Bus stall
	input wire logic path_alarm_out, // Alarm state
	input wire logic pointer_lost_out // Lost state
);
	logic [3:0] frm_ff;
	logic [1:0] out_ff;
	logic vld_ff, ais_ff, dis_ff;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// Frames since the outputs last moved; upper bound on the run counters
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			frm_ff <= 4'h0;
			out_ff <= 2'b00;
			vld_ff <= 1'b0;
			ais_ff <= 1'b0;
			dis_ff <= 1'b0;
		end else begin
			out_ff <= {path_alarm_out, pointer_lost_out};
			vld_ff <= ptr_valid;
			ais_ff <= ptr_valid && h1_byte == ALL_ONES && h2_byte == ALL_ONES;
			dis_ff <= ptr_valid && h1_byte[7:4] inside {4'h6, 4'he, 4'h2, 4'h4, 4'h7};
			if (out_ff != {path_alarm_out, pointer_lost_out}) frm_ff <= {3'h0, ptr_valid};
			else if (ptr_valid && frm_ff != 4'hf) frm_ff <= frm_ff + 4'h1;
		end
	end
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
	wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
		else $error("wait low without request");
	wait_prompt_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	one_state_a: assert property (!(path_alarm_out && pointer_lost_out)) else $error("two states");
	alarm_entry_a: assert property ($rose(path_alarm_out) |-> ais_ff && frm_ff >= 4'h3)
		else $error("alarm entry wrong");
	lost_no_ais_a: assert property ($rose(pointer_lost_out) && vld_ff |-> !ais_ff)
		else $error("all ones caused loss");
	lost_entry_a: assert property ($rose(pointer_lost_out) && vld_ff |-> frm_ff >= 4'h8)
		else $error("loss too early");
	lost_exit_a: assert property ($fell(pointer_lost_out) && !path_alarm_out |-> dis_ff && frm_ff >= 4'h3)
		else $error("loss cleared wrongly");
	alarm_exit_a: assert property ($fell(path_alarm_out) && !pointer_lost_out |-> vld_ff && !ais_ff)
		else $error("alarm cleared wrongly");
	frame_only_a: assert property ($changed(path_alarm_out) |-> vld_ff)
		else $error("alarm moved off frame");
endmodule
bind sonet_pointer_interpreter sonet_pointer_interpreter_checker chk_u (.mclk(mclk), .arst_n(arst_n),
	.h1_byte(h1_byte), .h2_byte(h2_byte), .ptr_valid(ptr_valid), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .path_alarm_out(path_alarm_out),
	.pointer_lost_out(pointer_lost_out));
`default_nettype wire

// file: dv/ptr_source.sv
`timescale 1ns/1ns
`default_nettype none
module ptr_source (
	input wire logic mclk, // Byte clock
	output logic [7:0] h1_byte, // Pointer byte one
	output logic [7:0] h2_byte, // Pointer byte two
	output logic ptr_valid // Frame strobe
);
	initial begin
		ptr_valid = 1'b0;
		h1_byte = 8'h00;
		h2_byte = 8'h00;
	end
	// Bytes flip outside the strobe so stale values never look valid
	task automatic frame(input logic [15:0] w, input int gap);
		repeat (gap) @(posedge mclk);
		h1_byte <= w[15:8];
		h2_byte <= w[7:0];
		ptr_valid <= 1'b1;
		@(posedge mclk);
		ptr_valid <= 1'b0;
		h1_byte <= ~w[15:8];
		h2_byte <= ~w[7:0];
	endtask
endmodule
`default_nettype wire

// file: dv/sonet_pointer_interpreter_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sonet_pointer_interpreter_bench import ptr_interp_pkg::*;;
	logic mclk, arst_n, ptr_valid, avs_read, avs_write, avs_waitrequest, path_alarm_out, pointer_lost_out;
	logic [7:0] h1_byte, h2_byte;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rv;
	int fails, tests_run;
	ptr_source src (.mclk(mclk), .h1_byte(h1_byte), .h2_byte(h2_byte), .ptr_valid(ptr_valid));
	sonet_pointer_interpreter dut_u (.mclk(mclk), .arst_n(arst_n), .h1_byte(h1_byte),
		.h2_byte(h2_byte), .ptr_valid(ptr_valid), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.path_alarm_out(path_alarm_out), .pointer_lost_out(pointer_lost_out));
	function automatic logic [15:0] pw(input logic [3:0] f, input logic [9:0] p);
		return {f, SS_SDH, p};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge mclk);
		while (avs_waitrequest) @(posedge mclk);
		rv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	task automatic ochk(input logic [1:0] e);
		#1;
		chk({30'h0, path_alarm_out, pointer_lost_out}, {30'h0, e});
	endtask
	task automatic frames(input logic [15:0] w, input int n);
		repeat (n) src.frame(w, 1);
	endtask
	task automatic t_reset;
		ochk(2'b01);
		rchk(OFS_CTRL, 32'h0);
		rchk(OFS_STATUS, 32'h400);
		rchk(OFS_POINTER, 32'h0);
		rchk(4'hc, 32'h0);
		frames(pw(4'h6, 10'h00a), 2);
		ochk(2'b01);
		frames(pw(4'h6, 10'h00a), 1);
		ochk(2'b00);
		rchk(OFS_POINTER, 32'h00a);
	endtask
	task automatic t_flags;
		logic [3:0] fl[10] = '{4'h9, 4'h1, 4'hd, 4'hb, 4'h8, 4'h6, 4'he, 4'h2, 4'h4, 4'h7};
		logic [9:0] p;
		frames(pw(4'h9, 10'h30f), 1);
		rchk(OFS_POINTER, 32'h00a);
		for (int i = 0; i < 10; i++) begin
			p = 10'h30e - 10'(i < 5 ? i : 4);
			if (i == 5) bus(1'b1, OFS_STATUS, 32'h1f);
			frames(pw(fl[i], p), 1);
			rchk(OFS_POINTER, {22'h0, p});
		end
		rchk(OFS_STATUS, 32'h100);
	endtask
	task automatic t_bad;
		logic [3:0] bad[6] = '{4'h0, 4'h3, 4'h5, 4'ha, 4'hc, 4'hf};
		foreach (bad[i]) begin
			bus(1'b1, OFS_STATUS, 32'h1f);
			frames(pw(bad[i], 10'h30a), 1);
			rchk(OFS_STATUS, 32'h103);
		end
		frames(pw(4'h0, 10'h30a), 1);
		ochk(2'b00);
		frames(pw(4'h0, 10'h30a), 1);
		ochk(2'b01);
		frames(pw(4'h6, 10'h30a), 3);
		ochk(2'b00);
	endtask
	task automatic t_adj;
		bus(1'b1, OFS_STATUS, 32'h1f);
		frames(pw(4'h6, 10'h30a ^ 10'h2a0), 1);
		rchk(OFS_POINTER, 32'h30b);
		frames(pw(4'h6, 10'h30b ^ 10'h150), 1);
		rchk(OFS_POINTER, 32'h30b);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rv & 32'h713, 32'h111);
		bus(1'b1, OFS_CTRL, 32'h2);
		frames(pw(4'h6, 10'h30b ^ 10'h150), 1);
		rchk(OFS_POINTER, 32'h30a);
		bus(1'b1, OFS_CTRL, 32'h4);
		rchk(OFS_CTRL, 32'h4);
		bus(1'b1, OFS_STATUS, 32'h1f);
		frames(pw(4'h6, 10'h30a ^ 10'h2a0), 1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rv & 32'h711, 32'h101);
		bus(1'b1, OFS_CTRL, 32'h0);
	endtask
	task automatic t_newp;
		frames(pw(4'h6, 10'h30a), 1);
		bus(1'b1, OFS_STATUS, 32'h1f);
		frames(pw(4'h6, 10'h309), 2);
		rchk(OFS_STATUS, 32'h105);
		bus(1'b1, OFS_STATUS, 32'h1f);
		frames(pw(4'h6, 10'h309), 1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rv & 32'h70c, 32'h108);
		rchk(OFS_POINTER, 32'h309);
		frames(pw(4'h6, 10'h309), 1);
		frames(pw(4'h0, 10'h309), 5);
		frames(pw(4'h6, 10'h300), 3);
		ochk(2'b00);
		rchk(OFS_POINTER, 32'h300);
	endtask
	task automatic t_ais;
		frames(16'hffff, 2);
		ochk(2'b00);
		frames(16'hffff, 1);
		ochk(2'b10);
		frames(16'hffff, 8);
		ochk(2'b10);
		frames(pw(4'h9, 10'h055), 1);
		ochk(2'b00);
		rchk(OFS_POINTER, 32'h055);
		bus(1'b1, OFS_STATUS, 32'h1f);
		src.frame({4'h6, 2'b00, 10'h055}, 4);
		rchk(OFS_STATUS, 32'h101);
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b1, OFS_STATUS, 32'h1f);
		src.frame({4'h6, 2'b00, 10'h055}, 4);
		rchk(OFS_STATUS, 32'h100);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	initial begin
		#400000;
		fails++;
		summarize();
	end
	initial begin
		arst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		t_reset();
		$display("reset test done");
		t_flags();
		$display("flag test done");
		t_bad();
		$display("bad flag test done");
		t_adj();
		$display("adjust test done");
		t_newp();
		$display("new pointer test done");
		t_ais();
		$display("alarm test done");
		summarize();
	end
endmodule
`default_nettype wire
